// [hw/tsc_consts.vh]
// tsc_consts.vh: offsets, field positions, reset values and counts of the
// timestamp and register-word codec; included by every design file.
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets (avalon, one aligned word each)
// ----------------------------------------------------------------
`define TSC_OFF_CTRL     8'h00
`define TSC_OFF_SETDATE  8'h04
`define TSC_OFF_SETTIME  8'h08
`define TSC_OFF_SETMS    8'h0C
`define TSC_OFF_PK0      8'h10
`define TSC_OFF_PK1      8'h14
`define TSC_OFF_PK2      8'h18
`define TSC_OFF_PK3      8'h1C
`define TSC_OFF_IEC0     8'h20
`define TSC_OFF_IEC1     8'h24
`define TSC_OFF_IEC2     8'h28
`define TSC_OFF_IEC3     8'h2C
`define TSC_OFF_IECQ     8'h30
`define TSC_OFF_STQ      8'h34
`define TSC_OFF_STW      8'h38
`define TSC_OFF_CNT0     8'h40
`define TSC_OFF_CNTHI    8'h50
`define TSC_OFF_CNTLO    8'h54

// ----------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------
`define TSC_CTRL_SYNC    0
`define TSC_CTRL_EXT     1
`define TSC_CTRL_EXTENDED_PACKED_TIMESTAMP   2
`define TSC_CTRL_CLR     3

// ----------------------------------------------------------------
// field positions of the encoded words
// ----------------------------------------------------------------
`define TSC_PK_HI_LSB    8
`define TSC_PK_SUSPECT   15
`define TSC_IEC_DAY_W    5
`define TSC_IEC_MON_LSB  8
`define TSC_IEC_MIN_W    6
`define TSC_IEC_HR_LSB   8
`define TSC_IEC_YR_W     7
`define TSC_Q_EXT        12
`define TSC_Q_SYNC       13
`define TSC_Q_DSET       14
`define TSC_SETDATE_MON  8
`define TSC_SETDATE_DAY  16
`define TSC_SETTIME_MIN  8
`define TSC_SETTIME_SEC  16

// ----------------------------------------------------------------
// reset values and arithmetic constants
// ----------------------------------------------------------------
`define TSC_RST_YEAR     8'h64
`define TSC_RST_MON      4'h1
`define TSC_RST_DAY      5'h01
`define TSC_YEAR_2000    8'h64
`define TSC_MS_PER_SEC   16'h03E8
`define TSC_DIGIT_MAX    14'h270F

`endif

// [hw/tsc_tenk_count.v]
// tsc_tenk_count.v: event counter kept directly in base ten thousand.
// assumes one clock, synchronous active-high reset, single-cycle step pulses.
`timescale 1ns/1ps
`include "tsc_consts.vh"
module tsc_tenk_count
#(
  parameter NW = 4
)
(
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire             i_clr,
  input  wire             i_step,
  output wire [16*NW-1:0] o_words
);
  reg     [13:0] dig_r [0:NW-1];
  reg     [NW:0] carry_in;
  integer        k;
  integer        j;

  // ----------------------------------------------------------------
  // carry chain: a digit passes the step on only while it sits at 9999
  // ----------------------------------------------------------------
  always @*
  begin
    carry_in[0] = i_step;
    for (j = 0; j < NW; j = j + 1)
      carry_in[j+1] = carry_in[j] && (dig_r[j] == `TSC_DIGIT_MAX);
  end

  // ----------------------------------------------------------------
  // digit ripple: each digit wraps at 9999 so no word leaves range
  // ----------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_rst || i_clr)
    begin
      for (k = 0; k < NW; k = k + 1)
        dig_r[k] <= 14'h0000;
    end
    else
    begin
      for (k = 0; k < NW; k = k + 1)
      begin
        if (carry_in[k])
        begin
          if (dig_r[k] == `TSC_DIGIT_MAX)
            dig_r[k] <= 14'h0000;
          else
            dig_r[k] <= dig_r[k] + 14'h0001;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NW; g = g + 1)
    begin : gw
      // word g weighs ten thousand to the power g
      assign o_words[16*g +: 16] = {2'b00, dig_r[g]};
    end
  endgenerate
endmodule

// [hw/tsc_ts_pack.v]
// tsc_ts_pack.v: combinational packing of held date/time fields into the
// packed, extended packed and iec-style words; fields assumed in range.
`timescale 1ns/1ps
`include "tsc_consts.vh"
module tsc_ts_pack
(
  input  wire [7:0]  i_year,
  input  wire [3:0]  i_mon,
  input  wire [4:0]  i_day,
  input  wire [4:0]  i_hour,
  input  wire [5:0]  i_min,
  input  wire [5:0]  i_sec,
  input  wire [9:0]  i_ms,
  input  wire        i_suspect,
  input  wire        i_extended_packed_timestamp,
  input  wire        i_ext,
  input  wire        i_sync,
  input  wire        i_dset,
  output wire [15:0] o_pk0,
  output wire [15:0] o_pk1,
  output wire [15:0] o_pk2,
  output wire [15:0] o_pk3,
  output wire [15:0] o_iec0,
  output wire [15:0] o_iec1,
  output wire [15:0] o_iec2,
  output wire [15:0] o_iec3,
  output wire [15:0] o_iecq
);
  wire [7:0]  yoff;
  wire [15:0] sec_ms;

  // years before 2000 have no iec code, they read as 2000
  assign yoff   = (i_year < `TSC_YEAR_2000) ? 8'h00 : (i_year - `TSC_YEAR_2000);
  assign sec_ms = {10'h000, i_sec} * `TSC_MS_PER_SEC;

  assign o_pk0  = {i_suspect, 3'b000, i_mon, 3'b000, i_day};
  assign o_pk1  = {i_year, 3'b000, i_hour};
  assign o_pk2  = {2'b00, i_min, 2'b00, i_sec};
  assign o_pk3  = i_extended_packed_timestamp ? {6'h00, i_ms} : 16'h0000;
  assign o_iec0 = {9'h000, yoff[6:0]};
  assign o_iec1 = {4'h0, i_mon, 3'b000, i_day};
  assign o_iec2 = {3'b000, i_hour, 2'b00, i_min};
  assign o_iec3 = sec_ms + {6'h00, i_ms};
  assign o_iecq = {1'b0, i_dset, i_sync, i_ext, 12'h000};
endmodule

// [hw/tsc_top.v]
// tsc_top.v: timestamp and register-word codec behind an avalon-mm slave.
// assumes one 40 MHz clock, synchronous active-high reset, avalon master
// that holds its request until waitrequest is sampled low.
//
// Function
// - every base-ten-thousand word stays within -9999 to +9999.
// - a base-ten-thousand counter is the sum of word k times 10000^k, lowest address least.
// - packed word one carries day and month, word three seconds low and minutes high.
// - packed word one bit 15 is set whenever the date and time may be wrong.
// - packed word two carries hours low and year code 80..199 high.
// - the extended packed variant adds a millisecond word, the plain one omits it.
// - iec word one carries the year offset from 2000 in bits 0 to 6.
// - iec words two to four carry day/month, minutes/hours and milliseconds.
// - the iec quality word sits right after the four iec timestamp words.
// - iec quality bits 12, 13 and 14 flag external sync, sync and date set.
// - the quality word of a status word sits at the address just below it.
// - other multiword values go most significant register first.
`timescale 1ns/1ps
`include "tsc_consts.vh"
module tsc_top
#(
  parameter CNT_WORDS = 4
)
(
  input  wire        I_REF_CLK,
  input  wire        I_RST,
  input  wire [7:0]  I_AVS_ADDRESS,
  input  wire        I_AVS_READ,
  input  wire        I_AVS_WRITE,
  input  wire [31:0] I_AVS_WRITEDATA,
  input  wire [3:0]  I_AVS_BYTEENABLE,
  output wire [31:0] O_AVS_READDATA,
  output wire        O_AVS_WAITREQUEST,
  input  wire        I_CNT_STEP,
  input  wire [15:0] I_STATUS_BITS,
  input  wire [15:0] I_STATUS_QUAL,
  output wire        O_DATE_SUSPECT
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [31:0] wmerge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0]  be;
    integer      b;
    begin
      wmerge = old_w;
      for (b = 0; b < 4; b = b + 1)
        if (be[b])
          wmerge[8*b +: 8] = new_w[8*b +: 8];
    end
  endfunction

  localparam [7:0] cnt_base = `TSC_OFF_CNT0;

  // counter window: aligned words only, words past CNT_WORDS stay unmapped
  function cnt_hit;
    input [7:0] addr;
    begin
      cnt_hit = (addr[7:4] == cnt_base[7:4]) && (addr[1:0] == 2'b00) &&
                ({30'h00000000, addr[3:2]} < CNT_WORDS);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [31:0]           rdata_r;
  reg                   wait_r;
  reg                   sync_r;
  reg                   ext_r;
  reg                   extended_packed_timestamp_r;
  reg                   dset_r;
  reg                   clr_r;
  reg                   suspect_r;
  reg  [7:0]            year_r;
  reg  [3:0]            mon_r;
  reg  [4:0]            day_r;
  reg  [4:0]            hour_r;
  reg  [5:0]            min_r;
  reg  [5:0]            sec_r;
  reg  [9:0]            ms_r;
  reg  [15:0]           stw_r;
  reg  [15:0]           stq_r;
  reg  [31:0]           bin_r;
  reg  [31:0]           rd_nxt;
  reg  [31:0]           wimg;

  wire                  req;
  wire                  wr_go;
  wire [15:0]           pk0;
  wire [15:0]           pk1;
  wire [15:0]           pk2;
  wire [15:0]           pk3;
  wire [15:0]           iec0;
  wire [15:0]           iec1;
  wire [15:0]           iec2;
  wire [15:0]           iec3;
  wire [15:0]           iecq;
  wire [16*CNT_WORDS-1:0] cnt_words;
  wire [31:0]           ctrl_img;
  wire [31:0]           date_img;
  wire [31:0]           time_img;
  wire [2:0]            cnt_idx;

  assign req       = I_AVS_READ | I_AVS_WRITE;
  assign wr_go     = I_AVS_WRITE & ~wait_r;
  assign cnt_idx   = {1'b0, I_AVS_ADDRESS[3:2]};
  assign ctrl_img  = {28'h0000000, 1'b0, extended_packed_timestamp_r, ext_r, sync_r};
  assign date_img  = {11'h000, day_r, 4'h0, mon_r, year_r};
  assign time_img  = {10'h000, sec_r, 2'b00, min_r, 3'b000, hour_r};

  assign O_AVS_READDATA    = rdata_r;
  assign O_AVS_WAITREQUEST = wait_r;
  assign O_DATE_SUSPECT    = suspect_r;

  // ----------------------------------------------------------------
  // encoders
  // ----------------------------------------------------------------
  tsc_ts_pack u_pack
  (
    .i_year    (year_r),
    .i_mon     (mon_r),
    .i_day     (day_r),
    .i_hour    (hour_r),
    .i_min     (min_r),
    .i_sec     (sec_r),
    .i_ms      (ms_r),
    .i_suspect (suspect_r),
    .i_extended_packed_timestamp   (extended_packed_timestamp_r),
    .i_ext     (ext_r),
    .i_sync    (sync_r),
    .i_dset    (dset_r),
    .o_pk0     (pk0),
    .o_pk1     (pk1),
    .o_pk2     (pk2),
    .o_pk3     (pk3),
    .o_iec0    (iec0),
    .o_iec1    (iec1),
    .o_iec2    (iec2),
    .o_iec3    (iec3),
    .o_iecq    (iecq)
  );

  tsc_tenk_count
  #(
    .NW (CNT_WORDS)
  )
  u_tenk
  (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_RST),
    .i_clr   (clr_r),
    .i_step  (I_CNT_STEP),
    .o_words (cnt_words)
  );

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then data stands at the release
  // ----------------------------------------------------------------
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
      wait_r <= 1'b1;
    else if (req && wait_r)
      wait_r <= 1'b0;
    else
      wait_r <= 1'b1;
  end

  // read data is taken as waitrequest falls and stands until the next access
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
      rdata_r <= 32'h00000000;
    else if (req && wait_r)
      rdata_r <= I_AVS_READ ? rd_nxt : 32'h00000000;
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (I_AVS_ADDRESS)
      `TSC_OFF_CTRL:    rd_nxt = ctrl_img;
      `TSC_OFF_SETDATE: rd_nxt = date_img;
      `TSC_OFF_SETTIME: rd_nxt = time_img;
      `TSC_OFF_SETMS:   rd_nxt = {22'h000000, ms_r};
      `TSC_OFF_PK0:     rd_nxt = {16'h0000, pk0};
      `TSC_OFF_PK1:     rd_nxt = {16'h0000, pk1};
      `TSC_OFF_PK2:     rd_nxt = {16'h0000, pk2};
      `TSC_OFF_PK3:     rd_nxt = {16'h0000, pk3};
      `TSC_OFF_IEC0:    rd_nxt = {16'h0000, iec0};
      `TSC_OFF_IEC1:    rd_nxt = {16'h0000, iec1};
      `TSC_OFF_IEC2:    rd_nxt = {16'h0000, iec2};
      `TSC_OFF_IEC3:    rd_nxt = {16'h0000, iec3};
      `TSC_OFF_IECQ:    rd_nxt = {16'h0000, iecq};
      `TSC_OFF_STQ:     rd_nxt = {16'h0000, stq_r};
      `TSC_OFF_STW:     rd_nxt = {16'h0000, stw_r};
      `TSC_OFF_CNTHI:   rd_nxt = {16'h0000, bin_r[31:16]};
      `TSC_OFF_CNTLO:   rd_nxt = {16'h0000, bin_r[15:0]};
      default:
      begin
        // counter words sit lowest first; words past CNT_WORDS read zero
        if (cnt_hit(I_AVS_ADDRESS))
          rd_nxt = {16'h0000, cnt_words[16*cnt_idx +: 16]};
        else
          rd_nxt = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // write image: merged with the current value under byte enables
  // ----------------------------------------------------------------
  always @*
  begin
    case (I_AVS_ADDRESS)
      `TSC_OFF_CTRL:    wimg = wmerge(ctrl_img, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
      `TSC_OFF_SETDATE: wimg = wmerge(date_img, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
      `TSC_OFF_SETTIME: wimg = wmerge(time_img, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
      `TSC_OFF_IEC0:    wimg = wmerge({16'h0000, iec0}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
      `TSC_OFF_IEC1:    wimg = wmerge({16'h0000, iec1}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
      `TSC_OFF_IEC2:    wimg = wmerge({16'h0000, iec2}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
      `TSC_OFF_IEC3:    wimg = wmerge({16'h0000, iec3}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
      default:          wimg = wmerge({22'h000000, ms_r}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
    endcase
  end

  // ----------------------------------------------------------------
  // control, date and time fields
  // ----------------------------------------------------------------
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      sync_r    <= 1'b0;
      ext_r     <= 1'b0;
      extended_packed_timestamp_r   <= 1'b0;
      dset_r    <= 1'b0;
      year_r    <= `TSC_RST_YEAR;
      mon_r     <= `TSC_RST_MON;
      day_r     <= `TSC_RST_DAY;
      hour_r    <= 5'h00;
      min_r     <= 6'h00;
      sec_r     <= 6'h00;
      ms_r      <= 10'h000;
    end
    else
    begin
      if (wr_go)
      begin
        case (I_AVS_ADDRESS)
          `TSC_OFF_CTRL:
          begin
            sync_r  <= wimg[`TSC_CTRL_SYNC];
            ext_r   <= wimg[`TSC_CTRL_EXT];
            extended_packed_timestamp_r <= wimg[`TSC_CTRL_EXTENDED_PACKED_TIMESTAMP];
          end
          `TSC_OFF_SETDATE:
          begin
            year_r  <= wimg[7:0];
            mon_r   <= wimg[`TSC_SETDATE_MON +: 4];
            day_r   <= wimg[`TSC_SETDATE_DAY +: 5];
            dset_r  <= 1'b1;
          end
          `TSC_OFF_SETTIME:
          begin
            hour_r  <= wimg[4:0];
            min_r   <= wimg[`TSC_SETTIME_MIN +: 6];
            sec_r   <= wimg[`TSC_SETTIME_SEC +: 6];
          end
          `TSC_OFF_SETMS:
            ms_r    <= wimg[9:0];
          `TSC_OFF_IEC0:
          begin
            // reserved bits 7 to 15 are dropped
            year_r  <= {1'b0, wimg[`TSC_IEC_YR_W-1:0]} + `TSC_YEAR_2000;
            dset_r  <= 1'b1;
          end
          `TSC_OFF_IEC1:
          begin
            day_r   <= wimg[`TSC_IEC_DAY_W-1:0];
            mon_r   <= wimg[`TSC_IEC_MON_LSB +: 4];
          end
          `TSC_OFF_IEC2:
          begin
            min_r   <= wimg[`TSC_IEC_MIN_W-1:0];
            hour_r  <= wimg[`TSC_IEC_HR_LSB +: 5];
          end
          default:
            ms_r    <= ms_r;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // captured status pair and date doubt flag
  // ----------------------------------------------------------------
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      stw_r     <= 16'h0000;
      stq_r     <= 16'h0000;
      suspect_r <= 1'b1;
    end
    else
    begin
      // quality and status are sampled together so a pair never tears
      stw_r     <= I_STATUS_BITS;
      stq_r     <= I_STATUS_QUAL;
      // after reset (power loss) or until software syncs, flag doubt
      suspect_r <= ~sync_r;
    end
  end

  // ----------------------------------------------------------------
  // counter clear: one-cycle pulse from a write of the clear bit
  // ----------------------------------------------------------------
  always @(posedge I_REF_CLK)
  begin
    // the clear bit is not stored, so it always reads back as zero
    if (I_RST)
      clr_r <= 1'b0;
    else
      clr_r <= wr_go && (I_AVS_ADDRESS == `TSC_OFF_CTRL) && wimg[`TSC_CTRL_CLR];
  end

  // ----------------------------------------------------------------
  // binary event total, kept beside the base-ten-thousand form
  // ----------------------------------------------------------------
  always @(posedge I_REF_CLK)
  begin
    if (I_RST || clr_r)
      bin_r <= 32'h00000000;
    else if (I_CNT_STEP)
      bin_r <= bin_r + 32'h00000001;
  end

endmodule

// [bench/tsc_checker.sv]
// tsc_checker.sv: concurrent checks on the codec's avalon and status ports.
// assumes one clock, synchronous active-high reset; bound into tsc_top.
`timescale 1ns/1ps
module tsc_checker
#(
  parameter CNT_WORDS = 4
)
(
  input wire        I_REF_CLK,
  input wire        I_RST,
  input wire [7:0]  I_AVS_ADDRESS,
  input wire        I_AVS_READ,
  input wire        I_AVS_WRITE,
  input wire [31:0] I_AVS_WRITEDATA,
  input wire [3:0]  I_AVS_BYTEENABLE,
  input wire [31:0] O_AVS_READDATA,
  input wire        O_AVS_WAITREQUEST,
  input wire        I_CNT_STEP,
  input wire [15:0] I_STATUS_BITS,
  input wire [15:0] I_STATUS_QUAL,
  input wire        O_DATE_SUSPECT
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  wire       rd_ok  = I_AVS_READ && O_AVS_WAITREQUEST;
  wire       ctl_wr = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == 8'h00
                      && I_AVS_BYTEENABLE[0];
  wire [7:0] a      = I_AVS_ADDRESS;
  logic      susp_nxt;
  logic      susp_r;
  assign susp_nxt = ctl_wr ? !I_AVS_WRITEDATA[0] : susp_r;
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
      susp_r <= 1'b1;
    else
      susp_r <= susp_nxt;
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  chk_wait_cause: assert property (!O_AVS_WAITREQUEST |-> $past(I_AVS_READ || I_AVS_WRITE))
    else $error("waitrequest low without a request");
  chk_wait_pulse: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  chk_read_unmapped: assert property (rd_ok && a == 8'h3C |=> O_AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_suspect_sync: assert property (ctl_wr |-> ##2 O_DATE_SUSPECT == susp_r)
    else $error("date suspect does not follow sync");
  chk_pk0_quality: assert property (rd_ok && a == 8'h10 |=>
    O_AVS_READDATA[15] == $past(O_DATE_SUSPECT) && O_AVS_READDATA[31:16] == 16'h0)
    else $error("packed word one quality bit wrong");
  chk_iecq_reserved: assert property (rd_ok && a == 8'h30 |=>
    O_AVS_READDATA[11:0] == 12'h0 && O_AVS_READDATA[31:15] == 17'h0)
    else $error("quality word reserved bits set");
  chk_iec_upper: assert property (rd_ok && a >= 8'h10 && a <= 8'h2C |=>
    O_AVS_READDATA[31:16] == 16'h0 && (a != 8'h20 || O_AVS_READDATA[15:7] == 9'h0))
    else $error("reserved bits of a timestamp word set");
  chk_status_pass: assert property (rd_ok && a == 8'h38 |=>
    O_AVS_READDATA == {16'h0, $past(I_STATUS_BITS, 2)})
    else $error("status word does not match pins");
  chk_qual_pass: assert property (rd_ok && a == 8'h34 |=>
    O_AVS_READDATA == {16'h0, $past(I_STATUS_QUAL, 2)})
    else $error("status quality word does not match pins");
  chk_digit_range: assert property (rd_ok && a >= 8'h40 && a < 8'h40 + 4 * CNT_WORDS |=>
    O_AVS_READDATA <= 32'h270F)
    else $error("counter word out of range");

  cov_read: cover property (rd_ok ##1 !O_AVS_WAITREQUEST);
  cov_write: cover property (ctl_wr);
  cov_step_run: cover property (I_CNT_STEP [*8]);
endmodule

bind tsc_top tsc_checker #(.CNT_WORDS(CNT_WORDS)) i_chk
(
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_CNT_STEP(I_CNT_STEP),
  .I_STATUS_BITS(I_STATUS_BITS), .I_STATUS_QUAL(I_STATUS_QUAL),
  .O_DATE_SUSPECT(O_DATE_SUSPECT)
);

// [bench/tsc_sup_model.sv]
// tsc_sup_model.sv: supervisor that reads and writes codec words over avalon.
// assumes the slave lowers waitrequest to finish; the bench bounds the wait.
`timescale 1ns/1ps
module tsc_sup_model
(
  input  wire         i_clk,
  input  wire         i_wait,
  output logic [7:0]  o_addr,
  output logic        o_rd,
  output logic        o_wr,
  output logic [31:0] o_wdata,
  output logic [3:0]  o_be
);
  initial
  begin
    o_addr = 8'hFF;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 32'hFFFFFFFF;
    o_be = 4'h0;
  end

  // ----------------------------------------------------------------
  // one transfer; released lines show the inverse so nothing stale passes
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_be <= w ? 4'hF : 4'h0;
    o_rd <= !w;
    o_wr <= w;
    do @(posedge i_clk); while (i_wait !== 1'b0);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  // a status bit is trusted only when qualified: 0 open, 1 closed, 2 invalid
  function automatic logic [1:0] contact(input logic q, input logic s);
    return q ? {1'b0, s} : 2'h2;
  endfunction
endmodule

// [bench/testbench.sv]
// testbench.sv: self-checking bench for the codec; reads go through a queue.
// assumes tsc_top and the supervisor model; 40 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); end end
module testbench;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wreq;
  logic        step;
  logic [15:0] sbits;
  logic [15:0] squal;
  logic        susp;
  int          err_count;
  int          comparisons;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic [1:0]  want;
  logic [31:0] yr, mo, dy, hr, mi, se, ms, sb, sq;

  tsc_top #(.CNT_WORDS(4)) i_dut
  (
    .I_REF_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq), .I_CNT_STEP(step),
    .I_STATUS_BITS(sbits), .I_STATUS_QUAL(squal), .O_DATE_SUSPECT(susp)
  );
  tsc_sup_model i_sup
  (
    .i_clk(clk), .i_wait(wreq), .o_addr(addr), .o_rd(rd), .o_wr(wr),
    .o_wdata(wdata), .o_be(be)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // monitor: each completed read is matched to the oldest note
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rd === 1'b1 && wreq === 1'b0)
    begin
      // take the note once, so a mismatch does not consume a second one
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
    end
  end

  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_sup.xfer(1'b0, a, 32'h0);
  endtask

  task automatic wrx(input logic [7:0] a, input logic [31:0] d);
    i_sup.xfer(1'b1, a, d);
  endtask

  task automatic finish_test;
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #2000000;
    err_count++;
    finish_test;
  end

  initial
  begin
    void'($urandom(32'h78312493));
    rst = 1'b1;
    step = 1'b0;
    sbits = 16'h0;
    squal = 16'h0;
    repeat (12) @(posedge clk);
    `CHK(susp, 1'b1)
    rst <= 1'b0;
    rdx(8'h10, 32'h8101);
    rdx(8'h14, 32'h6400);
    rdx(8'h1C, 32'h0);
    rdx(8'h24, 32'h0101);
    rdx(8'h30, 32'h0);
    rdx(8'h3C, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      yr = 80 + $urandom_range(119);
      mo = 1 + $urandom_range(11);
      dy = 1 + $urandom_range(30);
      hr = $urandom_range(23);
      mi = $urandom_range(59);
      se = $urandom_range(59);
      ms = $urandom_range(999);
      wrx(8'h04, (dy << 16) | (mo << 8) | yr);
      wrx(8'h08, (se << 16) | (mi << 8) | hr);
      wrx(8'h0C, ms);
      wrx(8'h00, 32'h7);
      rdx(8'h10, (mo << 8) | dy);
      rdx(8'h14, (yr << 8) | hr);
      rdx(8'h18, (mi << 8) | se);
      rdx(8'h1C, ms);
      rdx(8'h20, yr >= 100 ? yr - 100 : 32'h0);
      rdx(8'h24, (mo << 8) | dy);
      rdx(8'h28, (hr << 8) | mi);
      rdx(8'h2C, se * 1000 + ms);
      rdx(8'h30, 32'h7000);
      wrx(8'h00, 32'h0);
      rdx(8'h10, 32'h8000 | (mo << 8) | dy);
      rdx(8'h1C, 32'h0);
      rdx(8'h30, 32'h4000);
    end
    // reserved bits set on purpose must not leak into the fields
    wrx(8'h20, 32'hFFFFFF85);
    wrx(8'h28, 32'hFFFFF7FB);
    rdx(8'h20, 32'h5);
    rdx(8'h14, 32'h6917);
    rdx(8'h18, 32'h3B00 | se);
    // mid-run reset, as after a power loss: doubt flag and fields restart
    wrx(8'h00, 32'h1);
    rdx(8'h30, 32'h6000);
    `CHK(susp, 1'b0)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(susp, 1'b1)
    rst <= 1'b0;
    rdx(8'h10, 32'h8101);
    rdx(8'h30, 32'h0);
    wrx(8'h00, 32'h8);
    repeat (4) @(posedge clk);
    repeat (10005)
    begin
      step <= 1'b1;
      @(posedge clk);
    end
    step <= 1'b0;
    rdx(8'h40, 32'h5);
    rdx(8'h44, 32'h1);
    rdx(8'h48, 32'h0);
    rdx(8'h4C, 32'h0);
    rdx(8'h50, 32'h0);
    rdx(8'h54, 32'h2715);
    for (int i = 0; i < 3; i++)
    begin
      sb = $urandom_range(16'hFFFF);
      sq = $urandom_range(16'hFFFF);
      sbits <= sb[15:0];
      squal <= sq[15:0];
      repeat (2) @(posedge clk);
      rdx(8'h34, sq);
      rdx(8'h38, sb);
      // the reader judges each contact bit from the word just read
      for (int k = 0; k < 16; k++)
      begin
        want = sq[k] ? {1'b0, sb[k]} : 2'h2;
        `CHK(i_sup.contact(sq[k], rdata[k]), want)
      end
    end
    @(posedge clk);
    finish_test;
  end
endmodule
